// [core/rfds_seq.sv]
// direct command sequencer of the rf front end
// assumes analog done/compare inputs are asynchronous and data inputs stable when done rises
`timescale 1ns/1ps
`include "rfds_defs.svh"
module rfds_seq import rfds_pkg::*; #(
	parameter int unsigned P_CYC_SQUELCH = `RFDS_CYC_SQUELCH,  // squelch limit
	parameter int unsigned P_CYC_SETTLE  = `RFDS_CYC_SETTLE,   // regulator settling
	parameter int unsigned P_CYC_REGADJ  = `RFDS_CYC_REGADJ,   // regulator limit
	parameter int unsigned P_CYC_MODCAL  = `RFDS_CYC_MODCAL,   // modulation limit
	parameter int unsigned P_CYC_ANTCAL  = `RFDS_CYC_ANTCAL    // antenna limit
) (
	input  wire logic       i_core_clk,         // core clock 20 MHz
	input  wire logic       i_reset_n,          // async reset, active low
	input  wire logic       i_cmd_valid,        // direct command strobe
	input  wire logic [2:0] i_cmd_code,         // direct command code
	input  wire logic       i_master_en,        // operation control enable bit
	input  wire logic       i_tx_en,            // transmitter operating
	input  wire logic       i_rx_en,            // receiver operating
	input  wire logic       i_ext_reg_sel,      // external regulated voltage select
	input  wire logic       i_supply_5v,        // 1: 5 V supply mode, 0: 3.3 V
	input  wire logic       i_rx_on_req,        // receiver wants rx active
	input  wire logic       i_mask_cmd,         // mask from mask command
	input  wire logic       i_mask_timer,       // mask from mask timer
	input  wire logic [3:0] i_gain_cfg,         // manual gain from receiver config 4
	input  wire logic [3:0] i_rssi_level,       // measured rssi level
	input  wire logic       i_osc_stable,       // oscillator stable, async
	input  wire logic       i_margin_ok,        // rf supply 250 mV below main, async
	input  wire logic       i_squelch_done,     // squelch circuit done, async
	input  wire logic       i_mod_done,         // depth loop done, async
	input  wire logic       i_ant_done,         // tank resonance found, async
	input  wire logic       i_adc_done,         // converter done, async
	input  wire logic [7:0] i_mod_meas,         // measured depth code
	input  wire logic [7:0] i_trim_code,        // trim code from tuner
	input  wire logic [7:0] i_adc_data,         // raw converter code
	input  wire logic       i_adc_under,        // phase below converter range
	input  wire logic       i_adc_over,         // phase above converter range
	output logic            o_busy,             // a sequence is running
	output logic            o_chain_ok,         // next command may follow now
	output logic            o_cmd_irq,          // command termination pulse
	output logic            o_rx_active,        // masked receiver active
	output logic            o_squelch_run,      // squelch circuit enabled
	output logic            o_squelch_clear,    // clear squelch setting pulse
	output logic            o_agc_init,         // agc/squelch/rssi init pulse
	output logic      [3:0] o_manual_gain,      // loaded gain reduction
	output logic            o_force_rx_tx,      // force rx and tx on
	output logic            o_tx_force,         // force transmitter on
	output logic      [3:0] o_reg_step,         // regulator steps below max
	output logic            o_mod_cal_run,      // depth loop enabled
	output logic      [7:0] o_mod_depth_disp,   // depth display value
	output logic            o_ant_cal_run,      // tuner enabled
	output logic      [7:0] o_antenna_trim_outputs, // trim capacitor code
	output logic            o_phase_det_en,     // phase detector enabled
	output logic            o_adc_relative,     // converter relative mode
	output logic      [7:0] o_adc_result,       // converter output value
	output logic      [3:0] o_rssi              // rssi field of rx display
);
	localparam int unsigned N_SYNC = 6;
	localparam int unsigned CYC_PHS = `RFDS_CYC_PHASE; // phase limit, fixed
	localparam logic [`RFDS_TMR_W-1:0] LIM_SQL = P_CYC_SQUELCH[`RFDS_TMR_W-1:0];
	localparam logic [`RFDS_TMR_W-1:0] LIM_SET = P_CYC_SETTLE[`RFDS_TMR_W-1:0];
	localparam logic [`RFDS_TMR_W-1:0] LIM_REG = P_CYC_REGADJ[`RFDS_TMR_W-1:0];
	localparam logic [`RFDS_TMR_W-1:0] LIM_MOD = P_CYC_MODCAL[`RFDS_TMR_W-1:0];
	localparam logic [`RFDS_TMR_W-1:0] LIM_ANT = P_CYC_ANTCAL[`RFDS_TMR_W-1:0];
	localparam logic [`RFDS_TMR_W-1:0] LIM_PHS = CYC_PHS[`RFDS_TMR_W-1:0];
	localparam logic [`RFDS_TMR_W-1:0] ONE     = 17'h00001;

	rfds_state_t              state_q;
	rfds_state_t              state_d;
	logic [N_SYNC-1:0]        async_in;
	logic [N_SYNC-1:0]        sync1_q;
	logic [N_SYNC-1:0]        sync2_q;
	logic                     osc_ok;
	logic                     margin_ok;
	logic                     sql_done;
	logic                     mod_done;
	logic                     ant_done;
	logic                     adc_done;
	logic [`RFDS_TMR_W-1:0]   tmr_q;
	logic [`RFDS_TMR_W-1:0]   settle_q;
	logic [`RFDS_TMR_W-1:0]   limit;
	logic                     timeout;
	logic                     settled;
	logic                     gated;
	logic                     accept;
	logic                     is_gain_rst;
	logic                     is_rssi_clr;
	logic                     idle;
	logic                     finish;
	logic                     reg_stop;
	logic                     irq_d;

	// two-stage synchronisers for the analog and oscillator levels
	assign async_in = {i_adc_done, i_ant_done, i_mod_done, i_squelch_done,
		i_margin_ok, i_osc_stable};
	generate
		for (genvar g = 0; g < N_SYNC; g++) begin : g_sync
			always_ff @(posedge i_core_clk or negedge i_reset_n) begin
				if (!i_reset_n) begin
					sync1_q[g] <= 1'b0;
					sync2_q[g] <= 1'b0;
				end else begin
					sync1_q[g] <= async_in[g];
					sync2_q[g] <= sync1_q[g];
				end
			end
		end
	endgenerate
	assign osc_ok    = sync2_q[0];
	assign margin_ok = sync2_q[1];
	assign sql_done  = sync2_q[2];
	assign mod_done  = sync2_q[3];
	assign ant_done  = sync2_q[4];
	assign adc_done  = sync2_q[5];

	// receiver active is suppressed by either mask source
	assign o_rx_active = i_rx_on_req & ~(i_mask_cmd | i_mask_timer);

	// acceptance of a command strobe
	assign idle        = (state_q == RFDS_ST_IDLE);
	assign gated       = i_master_en & osc_ok;
	assign is_gain_rst = (i_cmd_code == `RFDS_CMD_GAIN_RST);
	assign is_rssi_clr = (i_cmd_code == `RFDS_CMD_RSSI_CLR);
	always_comb begin
		accept = 1'b0;
		case (i_cmd_code)
			`RFDS_CMD_SQUELCH:  accept = idle & i_tx_en & i_rx_en & ~o_rx_active;
			`RFDS_CMD_GAIN_RST: accept = gated;
			`RFDS_CMD_REG_ADJ:  accept = idle & gated & ~i_ext_reg_sel;
			`RFDS_CMD_MOD_CAL:  accept = idle & gated;
			`RFDS_CMD_ANT_CAL:  accept = idle & gated;
			`RFDS_CMD_PHASE:    accept = idle & gated;
			`RFDS_CMD_RSSI_CLR: accept = gated;
			default:            accept = 1'b0; // unknown codes are dropped
		endcase
		accept = accept & i_cmd_valid;
	end

	// per-state duration limit
	always_comb begin
		limit = LIM_PHS;
		unique case (state_q)
			RFDS_ST_IDLE:  limit = LIM_PHS;
			RFDS_ST_SQL:   limit = LIM_SQL;
			RFDS_ST_REG:   limit = LIM_REG;
			RFDS_ST_MOD:   limit = LIM_MOD;
			RFDS_ST_ANT:   limit = LIM_ANT;
			RFDS_ST_PHASE: limit = LIM_PHS;
		endcase
	end
	assign timeout  = (tmr_q >= limit - ONE);
	assign settled  = (settle_q >= LIM_SET - ONE);
	assign reg_stop = margin_ok || (o_reg_step == `RFDS_REG_STEP_MIN);

	// next state and completion
	always_comb begin
		state_d = state_q;
		finish  = 1'b0;
		unique case (state_q)
			RFDS_ST_IDLE: begin
				if (accept) begin
					case (i_cmd_code)
						`RFDS_CMD_SQUELCH: state_d = RFDS_ST_SQL;
						`RFDS_CMD_REG_ADJ: state_d = RFDS_ST_REG;
						`RFDS_CMD_MOD_CAL: state_d = RFDS_ST_MOD;
						`RFDS_CMD_ANT_CAL: state_d = RFDS_ST_ANT;
						`RFDS_CMD_PHASE:   state_d = RFDS_ST_PHASE;
						default:           state_d = RFDS_ST_IDLE;
					endcase
				end
			end
			RFDS_ST_SQL: begin
				if (i_cmd_valid && is_gain_rst && gated) begin
					state_d = RFDS_ST_IDLE;
				end else if (sql_done || timeout) begin
					state_d = RFDS_ST_IDLE;
				end
			end
			RFDS_ST_REG: begin
				finish = (settled && reg_stop) || timeout;
			end
			RFDS_ST_MOD: begin
				finish = mod_done || timeout;
			end
			RFDS_ST_ANT: begin
				finish = ant_done || timeout;
			end
			RFDS_ST_PHASE: begin
				finish = adc_done || timeout;
			end
		endcase
		if (finish) begin
			state_d = RFDS_ST_IDLE;
		end
	end

	// state register
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state_q <= RFDS_ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// total duration timer, restarted at each start
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			tmr_q <= '0;
		end else if (idle) begin
			tmr_q <= '0;
		end else begin
			tmr_q <= tmr_q + ONE;
		end
	end

	// regulator settling timer, restarted after each step
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			settle_q <= '0;
		end else if (state_q != RFDS_ST_REG || settled) begin
			settle_q <= '0;
		end else begin
			settle_q <= settle_q + ONE;
		end
	end

	// regulator setting: maximum at start, one step down on short margin
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_reg_step <= `RFDS_REG_STEP_MAX;
		end else if (idle && accept && i_cmd_code == `RFDS_CMD_REG_ADJ) begin
			o_reg_step <= `RFDS_REG_STEP_MAX;
		end else if (state_q == RFDS_ST_REG && settled && !reg_stop) begin
			o_reg_step <= o_reg_step + 4'h1;
		end
	end

	// termination interrupt for regulator, modulation and phase only
	assign irq_d = finish && (state_q == RFDS_ST_REG || state_q == RFDS_ST_MOD ||
		state_q == RFDS_ST_PHASE);
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_cmd_irq <= 1'b0;
		end else begin
			o_cmd_irq <= irq_d;
		end
	end

	// gain reset pulses and manual gain load
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_agc_init      <= 1'b0;
			o_squelch_clear <= 1'b0;
			o_manual_gain   <= 4'h0;
		end else begin
			o_agc_init      <= accept && is_gain_rst;
			o_squelch_clear <= accept && is_gain_rst;
			if (accept && is_gain_rst) begin
				o_manual_gain <= i_gain_cfg;
			end
		end
	end

	// calibration and measurement results
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_mod_depth_disp       <= 8'h00;
			o_antenna_trim_outputs <= 8'h00;
			o_adc_result           <= 8'h00;
		end else begin
			if (state_q == RFDS_ST_MOD && finish) begin
				o_mod_depth_disp <= i_mod_meas;
			end
			if (state_q == RFDS_ST_ANT) begin
				o_antenna_trim_outputs <= i_trim_code;
			end
			if (state_q == RFDS_ST_PHASE && finish) begin
				if (i_adc_under) begin
					o_adc_result <= `RFDS_PHASE_LOW_ANG;
				end else if (i_adc_over) begin
					o_adc_result <= `RFDS_PHASE_HIGH_ANG;
				end else begin
					o_adc_result <= i_adc_data;
				end
			end
		end
	end

	// analog enables follow the running state
	assign o_busy         = !idle;
	assign o_chain_ok     = idle;
	assign o_squelch_run  = (state_q == RFDS_ST_SQL);
	assign o_force_rx_tx  = (state_q == RFDS_ST_REG);
	assign o_tx_force     = (state_q == RFDS_ST_MOD) || (state_q == RFDS_ST_PHASE);
	assign o_mod_cal_run  = (state_q == RFDS_ST_MOD);
	assign o_ant_cal_run  = (state_q == RFDS_ST_ANT);
	assign o_phase_det_en = (state_q == RFDS_ST_PHASE);
	assign o_adc_relative = (state_q == RFDS_ST_PHASE);

	// rssi peak hold
	rfds_rssi_peak u_rssi (
		.i_core_clk  (i_core_clk),
		.i_reset_n   (i_reset_n),
		.i_rx_active (o_rx_active),
		.i_clear     (accept && is_rssi_clr),
		.i_level     (i_rssi_level),
		.o_rssi      (o_rssi)
	);

	// checks
	sequence s_reg_start;
		idle && accept && (i_cmd_code == `RFDS_CMD_REG_ADJ);
	endsequence
	sequence s_reg_max;
		(state_q == RFDS_ST_REG) && o_force_rx_tx && (o_reg_step == `RFDS_REG_STEP_MAX);
	endsequence

	chk_squelch_gate: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
		(idle && state_d == RFDS_ST_SQL) |-> (i_tx_en && i_rx_en && !o_rx_active))
		else $error("squelch started while not allowed");
	chk_squelch_bound: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
		(state_q == RFDS_ST_SQL) |-> (tmr_q < LIM_SQL))
		else $error("squelch overran");
	chk_gain_abort: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
		(state_q == RFDS_ST_SQL && accept && is_gain_rst) |=>
		(idle && o_agc_init && o_manual_gain == $past(i_gain_cfg)))
		else $error("gain reset did not abort squelch");
	chk_gate_master: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
		(accept && i_cmd_code != `RFDS_CMD_SQUELCH) |-> (i_master_en && osc_ok))
		else $error("command taken without enable");
	chk_irq_cause: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
		o_cmd_irq |-> ($past(state_q) == RFDS_ST_REG || $past(state_q) == RFDS_ST_MOD ||
		$past(state_q) == RFDS_ST_PHASE) && idle)
		else $error("irq from wrong command");
	chk_reg_start_max: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
		s_reg_start |=> s_reg_max)
		else $error("regulator not at maximum at start");
	chk_reg_step_settle: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
		(state_q == RFDS_ST_REG && o_reg_step != $past(o_reg_step) && !$past(idle)) |->
		$past(settled) && !$past(margin_ok))
		else $error("regulator stepped before settling");
	chk_reg_min: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
		o_reg_step <= `RFDS_REG_STEP_MIN)
		else $error("regulator below minimum");
	chk_reg_bound: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
		(state_q == RFDS_ST_REG) |-> (tmr_q < LIM_REG))
		else $error("regulator adjust overran");
	chk_ext_reject: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
		(idle && i_cmd_valid && i_cmd_code == `RFDS_CMD_REG_ADJ && i_ext_reg_sel) |=> idle)
		else $error("regulator adjust taken with external select");
	chk_phase_bound: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
		(idle && state_d == RFDS_ST_PHASE) |-> ##[1:501] idle)
		else $error("phase measurement overran");
	chk_mask_or: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
		(i_mask_cmd || i_mask_timer) |-> !o_rx_active)
		else $error("rx active under mask");
endmodule

// [core/rfds_defs.svh]
// constants of the direct command sequencer: codes, timing, regulator steps
// assumes a 20 MHz core clock; included by bare name from core/
//
// What this block does
// - squelch needs tx and rx on; runs only rx idle
// - squelch ends within 500 us
// - gain reset reinits agc, aborts squelch, loads gain
// - other commands need master enable and stable oscillator
// - chaining only after gain reset and rssi clear
// - regulator, modulation, phase commands raise done interrupt
// - squelch, gain reset, rssi clear raise none
// - regulator adjust starts rx, tx on, maximum setting
// - step down while margin to supply is short
// - compare only after 300 us settling each time
// - stop at margin reached or minimum setting
// - regulator adjust ends within 5 ms
// - reject regulator adjust with external voltage select
// - modulation calibration transmits, stores result, 275 us
// - antenna calibration trims tank within 250 us
// - phase measure: tx, detector, relative converter, store
// - phase code clamps FF below 30, 00 above 150
// - phase measurement ends within 25 us
// - rssi cleared on rx active rise, peak held
// - rssi clear zeroes fields, restarts peak measuring
// - two mask sources ORed suppress rx active
`ifndef RFDS_DEFS_SVH
`define RFDS_DEFS_SVH

// command codes on i_cmd_code
`define RFDS_CMD_SQUELCH   3'h0
`define RFDS_CMD_GAIN_RST  3'h1
`define RFDS_CMD_REG_ADJ   3'h2
`define RFDS_CMD_MOD_CAL   3'h3
`define RFDS_CMD_ANT_CAL   3'h4
`define RFDS_CMD_PHASE     3'h5
`define RFDS_CMD_RSSI_CLR  3'h6

// clock rate and printed times
`define RFDS_CLK_MHZ       20
`define RFDS_T_SQUELCH_US  500
`define RFDS_T_SETTLE_US   300
`define RFDS_T_REGADJ_US   5000
`define RFDS_T_MODCAL_US   275
`define RFDS_T_ANTCAL_US   250
`define RFDS_T_PHASE_US    25

// cycle counts (longest times round down, settle is a least time)
`define RFDS_CYC_SQUELCH   (`RFDS_T_SQUELCH_US * `RFDS_CLK_MHZ)
`define RFDS_CYC_SETTLE    (`RFDS_T_SETTLE_US * `RFDS_CLK_MHZ)
`define RFDS_CYC_REGADJ    (`RFDS_T_REGADJ_US * `RFDS_CLK_MHZ)
`define RFDS_CYC_MODCAL    (`RFDS_T_MODCAL_US * `RFDS_CLK_MHZ)
`define RFDS_CYC_ANTCAL    (`RFDS_T_ANTCAL_US * `RFDS_CLK_MHZ)
`define RFDS_CYC_PHASE     (`RFDS_T_PHASE_US * `RFDS_CLK_MHZ)

// regulator steps below maximum: 5.1 V..3.9 V by 120 mV, 3.4 V..2.4 V by 100 mV
`define RFDS_REG_STEP_MAX  4'h0
`define RFDS_REG_STEP_MIN  4'hA

// phase code clamps
`define RFDS_PHASE_LOW_ANG  8'hFF
`define RFDS_PHASE_HIGH_ANG 8'h00

`define RFDS_TMR_W         17

`endif

// [core/rfds_pkg.sv]
// types of the direct command sequencer
// assumes rfds_defs.svh for the numeric constants
package rfds_pkg;

	// sequencer states, one-hot
	typedef enum logic [5:0] {
		RFDS_ST_IDLE   = 6'h01,
		RFDS_ST_SQL    = 6'h02,
		RFDS_ST_REG    = 6'h04,
		RFDS_ST_MOD    = 6'h08,
		RFDS_ST_ANT    = 6'h10,
		RFDS_ST_PHASE  = 6'h20
	} rfds_state_t;

endpackage

// [core/rfds_rssi_peak.sv]
// rssi peak-hold field of the receiver state display
// assumes i_level is on the core clock; clears are single-cycle pulses
`timescale 1ns/1ps
`include "rfds_defs.svh"
module rfds_rssi_peak import rfds_pkg::*; (
	input  wire logic       i_core_clk,   // core clock
	input  wire logic       i_reset_n,    // async reset, active low
	input  wire logic       i_rx_active,  // receiver active level
	input  wire logic       i_clear,      // clear command pulse
	input  wire logic [3:0] i_level,      // measured rssi level
	output logic      [3:0] o_rssi        // held peak
);
	logic rx_act_q;
	logic rise;

	// edge of receiver active restarts the measurement
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rx_act_q <= 1'b0;
		end else begin
			rx_act_q <= i_rx_active;
		end
	end
	assign rise = i_rx_active & ~rx_act_q;

	// zero on rise or command, then follow the peak while active
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_rssi <= 4'h0;
		end else if (rise || i_clear) begin
			o_rssi <= 4'h0;
		end else if (i_rx_active && (i_level > o_rssi)) begin
			o_rssi <= i_level;
		end
	end

	chk_rssi_clear_zero: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
		(rise || i_clear) |=> (o_rssi == 4'h0)) else $error("rssi not zeroed");
	chk_rssi_peak_hold: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
		!(rise || i_clear) |=> (o_rssi >= $past(o_rssi))) else $error("rssi peak dropped");
endmodule

// [sim/rfds_analog_model.sv]
// analog side model: done flags, margin compare and measured data
// assumes run enables from rfds_seq and answer values set by the bench
`timescale 1ns/1ps
module rfds_analog_model (
	input  wire logic       i_core_clk,  // core clock
	input  wire logic       i_reset_n,   // async reset, active low
	input  wire logic       i_sql_run,   // squelch enable
	input  wire logic       i_mod_run,   // depth loop enable
	input  wire logic       i_ant_run,   // tuner enable
	input  wire logic       i_phase_run, // phase detector enable
	input  wire logic [3:0] i_step,      // regulator steps below max
	input  wire logic [3:0] i_need,      // steps needed for margin
	input  wire logic [7:0] i_dly,       // answer delay in cycles
	input  wire logic [7:0] i_val,       // value to report
	output logic            o_sql_done,  // squelch done
	output logic            o_mod_done,  // depth loop done
	output logic            o_ant_done,  // resonance found
	output logic            o_adc_done,  // conversion done
	output logic            o_margin_ok, // supply margin reached
	output logic      [7:0] o_data       // measured data
);
	logic [7:0] cnt_q; // cycles since a run began
	logic       done;
	// count while any squelch, depth, tuner or phase run is up, restart when all stop
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n)
			cnt_q <= 8'h00;
		else if (!(i_sql_run | i_mod_run | i_ant_run | i_phase_run))
			cnt_q <= 8'h00;
		else if (cnt_q != 8'hFF)
			cnt_q <= cnt_q + 8'h01;
	end
	// done flags stay up until the enable drops
	assign done        = (cnt_q >= i_dly);
	assign o_sql_done  = done & i_sql_run;
	assign o_mod_done  = done & i_mod_run;
	assign o_ant_done  = done & i_ant_run;
	assign o_adc_done  = done & i_phase_run;
	// data only valid with done, inverted otherwise so stale data shows
	assign o_data      = done ? i_val : ~i_val;
	// margin met once the setting is low enough
	assign o_margin_ok = (i_step >= i_need);
endmodule

// [sim/rfds_seq_tb_top.sv]
// self-checking bench of the direct command sequencer
// assumes shortened timing parameters and the analog side model
`timescale 1ns/1ps
`include "rfds_defs.svh"
module rfds_seq_tb_top;
	logic i_core_clk = 1'b0, i_reset_n = 1'b0, i_cmd_valid = 1'b0, i_master_en = 1'b1;
	logic i_tx_en = 1'b1, i_rx_en = 1'b1, i_ext_reg_sel = 1'b0, i_supply_5v = 1'b1;
	logic i_rx_on_req = 1'b0, i_mask_cmd = 1'b0, i_mask_timer = 1'b0, i_osc_stable = 1'b1;
	logic i_adc_under = 1'b0, i_adc_over = 1'b0;
	logic [2:0] i_cmd_code = 3'h7;
	logic [3:0] i_gain_cfg = 4'h0, i_rssi_level = 4'h0, need = 4'h0;
	logic [7:0] val = 8'h00, seed = 8'h2A, note_v;
	logic [10:0] note, exp_q[$];
	logic i_margin_ok, i_squelch_done, i_mod_done, i_ant_done, i_adc_done;
	logic [7:0] data;
	logic o_busy, o_chain_ok, o_cmd_irq, o_rx_active, o_squelch_run, o_squelch_clear;
	logic o_agc_init, o_force_rx_tx, o_tx_force, o_mod_cal_run, o_ant_cal_run;
	logic o_phase_det_en, o_adc_relative;
	logic [3:0] o_manual_gain, o_reg_step, o_rssi;
	logic [7:0] o_mod_depth_disp, o_antenna_trim_outputs, o_adc_result;
	int n_fail = 0, n_compared = 0, i;

	// 20 MHz core clock
	always #25 i_core_clk = ~i_core_clk;

	rfds_seq #(.P_CYC_SQUELCH(40), .P_CYC_SETTLE(20), .P_CYC_REGADJ(400),
		.P_CYC_MODCAL(30), .P_CYC_ANTCAL(30)) DUT (
		.i_core_clk, .i_reset_n, .i_cmd_valid, .i_cmd_code, .i_master_en, .i_tx_en,
		.i_rx_en, .i_ext_reg_sel, .i_supply_5v, .i_rx_on_req, .i_mask_cmd, .i_mask_timer,
		.i_gain_cfg, .i_rssi_level, .i_osc_stable, .i_margin_ok, .i_squelch_done,
		.i_mod_done, .i_ant_done, .i_adc_done, .i_mod_meas(data), .i_trim_code(data),
		.i_adc_data(data), .i_adc_under, .i_adc_over, .o_busy, .o_chain_ok, .o_cmd_irq,
		.o_rx_active, .o_squelch_run, .o_squelch_clear, .o_agc_init, .o_manual_gain,
		.o_force_rx_tx, .o_tx_force, .o_reg_step, .o_mod_cal_run, .o_mod_depth_disp,
		.o_ant_cal_run, .o_antenna_trim_outputs, .o_phase_det_en, .o_adc_relative,
		.o_adc_result, .o_rssi);

	rfds_analog_model u_ana (
		.i_core_clk, .i_reset_n, .i_sql_run(o_squelch_run), .i_mod_run(o_mod_cal_run),
		.i_ant_run(o_ant_cal_run), .i_phase_run(o_phase_det_en), .i_step(o_reg_step),
		.i_need(need), .i_dly(8'h06), .i_val(val), .o_sql_done(i_squelch_done),
		.o_mod_done(i_mod_done), .o_ant_done(i_ant_done), .o_adc_done(i_adc_done),
		.o_margin_ok(i_margin_ok), .o_data(data));

	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask

	task automatic wrap_up();
		$display("compared %0d, failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// one-cycle command strobe, returns in the cycle after the taking edge
	task automatic cmd(input logic [2:0] c);
		@(negedge i_core_clk);
		i_cmd_valid = 1'b1;
		i_cmd_code = c;
		@(negedge i_core_clk);
		i_cmd_valid = 1'b0;
	endtask

	task automatic wait_idle();
		int k;
		for (k = 0; k < 600 && o_busy !== 1'b0; k++)
			@(negedge i_core_clk);
		if (o_busy !== 1'b0) begin
			n_fail++;
			$display("unexpected at %0t: sequence hung", $time);
			wrap_up();
		end
	endtask

	// compare each termination pulse with the oldest note
	always @(negedge i_core_clk) begin
		if (o_cmd_irq === 1'b1) begin
			if (exp_q.size() == 0)
				check(8'h01, 8'h00);
			else begin
				note = exp_q.pop_front();
				note_v = note[7:0];
				case (note[10:8])
					3'h5: check(o_adc_result, note_v);
					3'h2: check({4'h0, o_reg_step}, note_v);
					default: check(o_mod_depth_disp, note_v);
				endcase
			end
		end
	end

	// main sequence
	initial begin
		repeat (3) @(posedge i_core_clk);
		@(negedge i_core_clk);
		i_reset_n = 1'b1;
		repeat (3) @(negedge i_core_clk);
		i_rx_on_req = 1'b1;
		for (i = 0; i < 4; i++) begin
			@(negedge i_core_clk);
			{i_mask_cmd, i_mask_timer} = i[1:0];
			#1 check({7'h0, o_rx_active}, (i == 0) ? 8'h01 : 8'h00);
		end
		i_mask_cmd = 1'b0;
		i_mask_timer = 1'b0;
		// peak hold, clear on rise of rx active, clear command
		i_rssi_level = 4'h9;
		repeat (4) @(negedge i_core_clk);
		i_rssi_level = 4'h5;
		repeat (4) @(negedge i_core_clk);
		check({4'h0, o_rssi}, 8'h09);
		i_rx_on_req = 1'b0;
		i_rssi_level = 4'h4;
		repeat (2) @(negedge i_core_clk);
		i_rx_on_req = 1'b1;
		repeat (4) @(negedge i_core_clk);
		check({4'h0, o_rssi}, 8'h04);
		i_rssi_level = 4'h0;
		cmd(`RFDS_CMD_RSSI_CLR);
		check({4'h0, o_rssi}, 8'h00);
		i_rssi_level = 4'h3;
		repeat (4) @(negedge i_core_clk);
		check({4'h0, o_rssi}, 8'h03);
		// squelch refused while rx active, then run and aborted
		cmd(`RFDS_CMD_SQUELCH);
		check({7'h0, o_busy}, 8'h00);
		i_rx_on_req = 1'b0;
		i_tx_en = 1'b0;
		cmd(`RFDS_CMD_SQUELCH);
		check({7'h0, o_busy}, 8'h00);
		i_tx_en = 1'b1;
		cmd(`RFDS_CMD_SQUELCH);
		check({7'h0, o_squelch_run}, 8'h01);
		i_gain_cfg = 4'hB;
		cmd(`RFDS_CMD_GAIN_RST);
		check({o_squelch_run, o_squelch_clear, o_agc_init, 1'b0, o_manual_gain}, 8'h6B);
		check({7'h0, o_chain_ok}, 8'h01);
		cmd(`RFDS_CMD_SQUELCH);
		wait_idle();
		// gated commands refused without enable, code 7 ignored
		i_master_en = 1'b0;
		cmd(`RFDS_CMD_PHASE);
		check({7'h0, o_busy}, 8'h00);
		i_master_en = 1'b1;
		// oscillator not stable: synchroniser needs two edges each way
		i_osc_stable = 1'b0;
		repeat (3) @(negedge i_core_clk);
		cmd(`RFDS_CMD_MOD_CAL);
		check({7'h0, o_busy}, 8'h00);
		i_osc_stable = 1'b1;
		repeat (3) @(negedge i_core_clk);
		cmd(3'h7);
		check({7'h0, o_busy}, 8'h00);
		// phase: plain, below range, above range
		for (i = 0; i < 3; i++) begin
			seed = lfsr(seed);
			val = seed;
			i_adc_under = (i == 1);
			i_adc_over = (i == 2);
			exp_q.push_back({3'h5, (i == 1) ? 8'hFF : (i == 2) ? 8'h00 : seed});
			cmd(`RFDS_CMD_PHASE);
			check({5'h0, o_phase_det_en, o_adc_relative, o_tx_force}, 8'h07);
			check({7'h0, o_chain_ok}, 8'h00);
			wait_idle();
		end
		// modulation and antenna calibration
		seed = lfsr(seed);
		val = seed;
		exp_q.push_back({3'h3, seed});
		cmd(`RFDS_CMD_MOD_CAL);
		check({6'h0, o_mod_cal_run, o_tx_force}, 8'h03);
		wait_idle();
		seed = lfsr(seed);
		val = seed;
		cmd(`RFDS_CMD_ANT_CAL);
		check({7'h0, o_ant_cal_run}, 8'h01);
		wait_idle();
		check(o_antenna_trim_outputs, seed);
		// regulator: refused by external select, margin after 3 steps, minimum
		i_ext_reg_sel = 1'b1;
		cmd(`RFDS_CMD_REG_ADJ);
		check({7'h0, o_busy}, 8'h00);
		i_ext_reg_sel = 1'b0;
		for (i = 0; i < 2; i++) begin
			need = (i == 0) ? 4'h3 : 4'hF;
			i_supply_5v = (i == 0); // same step count in both supply modes
			exp_q.push_back({3'h2, (i == 0) ? 8'h03 : 8'h0A});
			cmd(`RFDS_CMD_REG_ADJ);
			check({3'h0, o_force_rx_tx, o_reg_step}, 8'h10);
			repeat (15) @(negedge i_core_clk);
			check({4'h0, o_reg_step}, 8'h00);
			wait_idle();
		end
		repeat (4) @(negedge i_core_clk);
		check(8'(exp_q.size()), 8'h00);
		wrap_up();
	end
endmodule
